// File: inc/adc_ctrl_pkg.sv
// shared constants and state encoding for the converter sequencing and readout block
package adc_ctrl_pkg;

    // result word width
    localparam int RES_W = 18;

    // internal oscillator rate, in MHz
    localparam int CLK_MHZ = 40;

    // conversion time bounds, in ns
    localparam int CONV_MIN_NS = 500;
    localparam int CONV_MAX_NS = 700;

    // least time rounds up, longest time rounds down
    localparam int CONV_MIN_CYC = (CONV_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_MAX_CYC = (CONV_MAX_NS * CLK_MHZ) / 1000;

    // width of the cycle and edge counters
    localparam int CNT_W = 5;

    // serial clock falling edges after which the output is released
    localparam logic [4:0] FALLS_NO_BUSY = 5'h12;
    localparam logic [4:0] FALLS_BUSY = 5'h13;

    // jitter source for the conversion length
    localparam logic [7:0] LFSR_SEED = 8'hA5;
    localparam logic [7:0] LFSR_TAPS = 8'hB8;

    // result held after reset, before the first conversion
    localparam logic [17:0] RESULT_RST = 18'h00000;

    // saturation limits of the signed result
    localparam logic [17:0] RESULT_POS_FS = 18'h1FFFF;
    localparam logic [17:0] RESULT_NEG_FS = 18'h20000;

    // sequencing states
    typedef enum logic [2:0] {
        ST_ACQ = 3'b000,
        ST_CONV = 3'b001,
        ST_BUSY = 3'b010,
        ST_SHIFT = 3'b011,
        ST_DONE = 3'b100
    } state_t;

endpackage

// File: rtl/adc_sync2.sv
// two flip-flop synchroniser for levels entering the internal clock domain
`timescale 1ns/1ps

module adc_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // asynchronous level in, synchronised level out
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] q;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    // first stage feeds only the second stage
    always_comb begin
        s_nxt.meta = d_in;
        s_nxt.q = s_r.meta;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_out = s_r.q;

endmodule

// File: rtl/adc_link_edge.sv
// serial clock domain: marks each falling edge and captures the chain input
`timescale 1ns/1ps

module adc_link_edge (
    // link clock and reset
    input wire logic sclk_in,
    input wire logic sys_rst_in,
    // chain input from the previous device
    input wire logic din_in,
    // edge toggle and captured chain bit
    output logic fall_tog_out,
    output logic din_cap_out
);

    typedef struct packed {
        logic tog;
        logic din_cap;
    } link_state_t;

    link_state_t s_r;
    link_state_t s_nxt;

    // a toggle survives the crossing however the two clocks line up;
    // the captured bit stays put until the next edge, long after the toggle is seen
    always_comb begin
        s_nxt.tog = ~s_r.tog;
        s_nxt.din_cap = din_in;
    end

    // the serial clock may stand still between frames; nothing here needs it to run
    always_ff @(negedge sclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign fall_tog_out = s_r.tog;
    assign din_cap_out = s_r.din_cap;

endmodule

// File: rtl/adc_conv_ctrl.sv
// conversion sequencing and serial readout of the differential converter
`timescale 1ns/1ps

// structure
// the internal clock runs the sequencer; the serial clock only feeds the link stage
// the link stage flips a toggle on each falling edge and keeps the chain bit it saw
// the toggle crosses through two flops; the chain bit is read only once the toggle
// has landed, so it has then been still for at least two internal cycles
// convert_start and din pass a two-flop stage before the sequencer reads them
// the analog codes are synchronised as well, but a bus of bits can skew, so the
// host keeps them still for a few cycles on either side of the start edge
// reset is asynchronous and leaves the device powered down with the pin released
// nothing needs the serial clock to run while reset is applied
// sequencing
// acquisition: powered down, inputs connected, result waiting in the shift register
// conversion: inputs disconnected, length in internal cycles drawn from a small lfsr
// busy: low indicator bit on the data pin, waiting for the first serial fall
// shift: one result bit per serial falling edge, msb first
// done: data pin released, nothing moves until the next start edge
// the held result and the shift register are loaded together at the end of a
// conversion; only the shift register moves during readout
// interface options
// the mode is the din level taken with the start edge
// chip-select mode: select is active while either convert_start or din is low,
// which covers the 3-wire hookup (din tied high) and the 4-wire one
// (convert_start held high, din used as the select)
// daisy-chain mode: convert_start low alone selects and edges are not counted;
// the chain bit enters the bottom of the shift register on every fall, so the
// upstream result follows ours out of the pin
// a busy bit is given only when select is already active as the conversion ends;
// the host must then have lowered select before the shortest conversion is over
// chip-select frames end after a fixed count of falls or on a select rise
// limitations
// a start edge always wins: it aborts any readout or conversion in progress
// serial edges during conversion, before select or after release are dropped
// the serial clock must be slow enough for each toggle to be seen on its own:
// one serial period must span at least five internal cycles
// data changes two to three internal cycles after each serial fall, so the host
// samples a bit just before the next fall, not on the fall that launched it
// the output enable stands for the pin driver; the pad itself lives outside
// saturation keeps the signed difference inside the eighteen-bit code range
// outputs
// every pin and status output is a flop of the state record
// dout means something only while the enable is high

module adc_conv_ctrl (
    // internal clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // serial clock from the host, a clock domain of its own
    input wire logic sclk_in,
    // control pins
    input wire logic convert_start_in,
    input wire logic din_in,
    // analog inputs, as codes
    input wire logic [17:0] analog_pos_input_in,
    input wire logic [17:0] analog_neg_input_in,
    // serial data pin
    output logic dout_out,
    output logic dout_oe_out,
    // analog front end and status
    output logic sample_connect_out,
    output logic converting_out,
    output logic power_down_out,
    output logic cs_mode_out,
    output logic busy_ind_out
);

    typedef struct packed {
        // sequencing and conversion timing
        adc_ctrl_pkg::state_t state;
        logic [4:0] cnt;
        logic [4:0] conv_len;
        logic [7:0] lfsr;
        // sampled inputs and the finished code
        logic [17:0] cap_pos;
        logic [17:0] cap_neg;
        logic [17:0] result;
        logic [17:0] shreg;
        // readout bookkeeping
        logic [4:0] falls;
        logic cs_mode;
        logic busy_ind;
        // previous levels for the edge flags
        logic cnv_prev;
        logic sel_prev;
        logic tog_prev;
        // registered pins and status
        logic dout;
        logic oe;
        logic sample_conn;
        logic converting;
        logic power_down;
    } ctrl_state_t;

    ctrl_state_t s_r;
    ctrl_state_t s_nxt;

    // synchronised pin levels
    logic cnv_s;
    logic din_s;
    logic tog_s;
    // link domain outputs, then the synchronised analog codes
    logic fall_tog;
    logic din_cap;
    logic [35:0] analog_s;

    // signed difference, saturated to the result range
    // twenty bits hold any difference of two eighteen-bit codes
    function automatic logic [17:0] twos_diff(input logic [17:0] pos, input logic [17:0] neg);
        logic signed [19:0] d;
        d = $signed({2'h0, pos}) - $signed({2'h0, neg});
        if (d > $signed({2'h0, adc_ctrl_pkg::RESULT_POS_FS})) begin
            twos_diff = adc_ctrl_pkg::RESULT_POS_FS;
        end else if (d < $signed({2'h3, adc_ctrl_pkg::RESULT_NEG_FS})) begin
            twos_diff = adc_ctrl_pkg::RESULT_NEG_FS;
        end else begin
            twos_diff = d[17:0];
        end
    endfunction

    // select level as the pins stand: chip-select mode frames on either pin,
    // daisy-chain mode on convert_start alone
    function automatic logic select_level(input logic cs_mode, input logic cnv, input logic din);
        select_level = cs_mode ? ~(cnv & din) : ~cnv;
    endfunction

    // galois lfsr, one step per internal cycle
    function automatic logic [7:0] lfsr_step(input logic [7:0] lfsr);
        lfsr_step = lfsr[0] ? ((lfsr >> 1) ^ adc_ctrl_pkg::LFSR_TAPS) : (lfsr >> 1);
    endfunction

    // minimum length plus 0..8 cycles, so the length never leaves the two bounds
    function automatic logic [4:0] conv_length(input logic [7:0] lfsr);
        conv_length = 5'(adc_ctrl_pkg::CONV_MIN_CYC) + {2'h0, lfsr[2:0]} + {4'h0, lfsr[3]};
    endfunction

    // pins enter through two flops before the sequencer looks at them
    adc_sync2 #(.WIDTH(2)) u_sync_ctrl (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .d_in({convert_start_in, din_in}),
        .q_out({cnv_s, din_s})
    );

    // analog codes are assumed to settle well ahead of the start edge
    adc_sync2 #(.WIDTH(36)) u_sync_analog (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .d_in({analog_pos_input_in, analog_neg_input_in}),
        .q_out(analog_s)
    );

    // serial clock edges and the chain bit come from the link domain
    adc_link_edge u_link (
        .sclk_in(sclk_in),
        .sys_rst_in(sys_rst_in),
        .din_in(din_in),
        .fall_tog_out(fall_tog),
        .din_cap_out(din_cap)
    );

    // only the toggle crosses as a level; it changes once per serial fall
    adc_sync2 #(.WIDTH(1)) u_sync_tog (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .d_in(fall_tog),
        .q_out(tog_s)
    );

    // whole sequencer in one process
    // the order of priority, highest first:
    //   a start edge, which starts a new conversion whatever the state
    //   a select rise in chip-select mode, which releases the pin
    //   a serial falling edge, which moves the next bit to the pin
    // edge flags are formed from the registered levels of the previous cycle,
    // so each pin edge yields exactly one cycle of its flag
    // the previous select level resets as active, so a select that is
    // already low when reset ends is not mistaken for a fresh fall
    always_comb begin
        logic cnv_rise;
        logic sel_active;
        logic sel_fall;
        logic sel_rise;
        logic fall;
        logic [4:0] limit;
        logic [4:0] falls_inc;

        // hold everything unless a branch below moves it
        s_nxt = s_r;

        // chip-select is low while either pin is low in chip-select mode
        // (3-wire holds din high, 4-wire holds convert_start high);
        // in daisy-chain mode convert_start alone frames the transfer
        cnv_rise = cnv_s & ~s_r.cnv_prev;
        sel_active = select_level(s_r.cs_mode, cnv_s, din_s);
        sel_fall = sel_active & ~s_r.sel_prev;
        sel_rise = ~sel_active & s_r.sel_prev;
        fall = tog_s ^ s_r.tog_prev;
        limit = s_r.busy_ind ? adc_ctrl_pkg::FALLS_BUSY : adc_ctrl_pkg::FALLS_NO_BUSY;
        falls_inc = s_r.falls + 5'h01;

        // levels kept for the next cycle's edge flags
        s_nxt.cnv_prev = cnv_s;
        s_nxt.sel_prev = sel_active;
        s_nxt.tog_prev = tog_s;

        // free-running jitter source for the conversion length
        s_nxt.lfsr = lfsr_step(s_r.lfsr);

        // start edge first: it outranks every state below
        if (cnv_rise) begin
            // a start edge wins over any readout in progress
            s_nxt.state = adc_ctrl_pkg::ST_CONV;
            s_nxt.oe = 1'b0;
            s_nxt.cap_pos = analog_s[35:18];
            s_nxt.cap_neg = analog_s[17:0];
            s_nxt.sample_conn = 1'b0;
            s_nxt.converting = 1'b1;
            s_nxt.power_down = 1'b0;
            s_nxt.cs_mode = din_s;
            s_nxt.cnt = '0;
            // 0..8 extra cycles keep the length between the two bounds
            s_nxt.conv_len = conv_length(s_r.lfsr);
            s_nxt.falls = '0;
        end else begin
            // otherwise the state decides what the flags mean
            unique case (s_r.state)
                adc_ctrl_pkg::ST_ACQ: begin
                    // result waits here; serial edges before the select fall are ignored
                    if (sel_fall) begin
                        s_nxt.dout = s_r.shreg[17];
                        s_nxt.oe = 1'b1;
                        s_nxt.falls = '0;
                        s_nxt.state = adc_ctrl_pkg::ST_SHIFT;
                    end
                end
                adc_ctrl_pkg::ST_CONV: begin
                    // only internal clock cycles advance the conversion
                    s_nxt.cnt = s_r.cnt + 5'h01;
                    if (s_r.cnt == s_r.conv_len - 5'h01) begin
                        // the code lands in the held result and the shift register at once
                        s_nxt.result = twos_diff(s_r.cap_pos, s_r.cap_neg);
                        s_nxt.shreg = twos_diff(s_r.cap_pos, s_r.cap_neg);
                        s_nxt.sample_conn = 1'b1;
                        s_nxt.converting = 1'b0;
                        s_nxt.power_down = 1'b1;
                        s_nxt.falls = '0;
                        // select already low at the end asks for the busy bit
                        s_nxt.busy_ind = sel_active;
                        if (sel_active) begin
                            s_nxt.dout = 1'b0;
                            s_nxt.oe = 1'b1;
                            s_nxt.state = adc_ctrl_pkg::ST_BUSY;
                        end else begin
                            s_nxt.state = adc_ctrl_pkg::ST_ACQ;
                        end
                    end
                end
                adc_ctrl_pkg::ST_BUSY: begin
                    // a select rise releases the pin before any edge is used
                    if (s_r.cs_mode && sel_rise) begin
                        s_nxt.oe = 1'b0;
                        s_nxt.state = adc_ctrl_pkg::ST_DONE;
                    end else if (fall) begin
                        // the first edge replaces the busy bit with the MSB
                        s_nxt.dout = s_r.shreg[17];
                        s_nxt.falls = 5'h01;
                        s_nxt.state = adc_ctrl_pkg::ST_SHIFT;
                    end
                end
                adc_ctrl_pkg::ST_SHIFT: begin
                    if (s_r.cs_mode && sel_rise) begin
                        s_nxt.oe = 1'b0;
                        s_nxt.state = adc_ctrl_pkg::ST_DONE;
                    end else if (fall) begin
                        // chain bit enters at the bottom so upstream results follow ours
                        s_nxt.shreg = {s_r.shreg[16:0], din_cap};
                        s_nxt.dout = s_r.shreg[16];
                        // count falls only where the frame has a fixed length
                        if (s_r.cs_mode) begin
                            s_nxt.falls = falls_inc;
                            if (falls_inc == limit) begin
                                s_nxt.oe = 1'b0;
                                s_nxt.state = adc_ctrl_pkg::ST_DONE;
                            end
                        end
                    end
                end
                adc_ctrl_pkg::ST_DONE: begin
                    // output stays released until the next start edge
                    s_nxt.oe = 1'b0;
                end
                default: begin
                    s_nxt.state = adc_ctrl_pkg::ST_ACQ;
                    s_nxt.oe = 1'b0;
                end
            endcase
        end
    end

    // reset leaves the device powered down in acquisition with the output released
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_r <= '0;
            s_r.state <= adc_ctrl_pkg::ST_ACQ;
            s_r.lfsr <= adc_ctrl_pkg::LFSR_SEED;
            s_r.result <= adc_ctrl_pkg::RESULT_RST;
            s_r.shreg <= adc_ctrl_pkg::RESULT_RST;
            s_r.cs_mode <= 1'b1;
            // select counted as active, so a low pin at release is no edge
            s_r.sel_prev <= 1'b1;
            s_r.sample_conn <= 1'b1;
            s_r.power_down <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // every output straight from a flop
    assign dout_out = s_r.dout;
    assign dout_oe_out = s_r.oe;
    assign sample_connect_out = s_r.sample_conn;
    assign converting_out = s_r.converting;
    assign power_down_out = s_r.power_down;
    assign cs_mode_out = s_r.cs_mode;
    assign busy_ind_out = s_r.busy_ind;

endmodule

// File: testbench/adc_conv_ctrl_assertions.sv
// concurrent checks on the converter sequencing and readout pins
`timescale 1ns/1ps

module adc_conv_ctrl_assertions (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // control pins
    input wire logic convert_start_in,
    input wire logic din_in,
    // outputs watched
    input wire logic dout_out,
    input wire logic dout_oe_out,
    input wire logic sample_connect_out,
    input wire logic converting_out,
    input wire logic power_down_out,
    input wire logic cs_mode_out,
    input wire logic busy_ind_out
);
    logic [5:0] len_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    // cycles the conversion has stood; the max check fires long before this could wrap
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            len_r <= 6'h00;
        end else begin
            len_r <= converting_out ? len_r + 6'h01 : 6'h00;
        end
    end

    a_conv_min: assert property ($fell(converting_out) |-> len_r >= 6'h14)
        else $error("conversion shorter than the minimum");
    a_conv_max: assert property (converting_out |-> len_r < 6'h1C)
        else $error("conversion longer than the maximum");
    a_conv_isolate: assert property (
        converting_out |-> !sample_connect_out && !power_down_out)
        else $error("inputs connected or powered down while converting");
    a_start_conv: assert property ($rose(convert_start_in) |-> ##[2:4] converting_out)
        else $error("start edge did not begin a conversion");
    a_start_release: assert property (
        $rose(convert_start_in) |-> ##[2:4] !dout_oe_out)
        else $error("start edge did not release the data pin");
    a_end_acq: assert property (
        $fell(converting_out) |-> power_down_out && sample_connect_out)
        else $error("no acquisition after conversion end");
    a_conv_quiet: assert property (converting_out |-> !dout_oe_out)
        else $error("data pin driven during conversion");
    a_mode_latch: assert property ($rose(converting_out) |-> cs_mode_out == din_in)
        else $error("interface mode not taken from the select pin");
    a_busy_low: assert property ($rose(busy_ind_out) |-> dout_oe_out && !dout_out)
        else $error("busy bit not driven low");
    a_sel_release: assert property (
        cs_mode_out && $rose(convert_start_in && din_in) |-> ##[2:5] !dout_oe_out)
        else $error("select rise did not release the data pin");

    c_busy: cover property ($rose(busy_ind_out));
    c_daisy: cover property (!cs_mode_out && $fell(converting_out));
    c_release: cover property ($fell(dout_oe_out) && power_down_out);
endmodule

bind adc_conv_ctrl adc_conv_ctrl_assertions chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .convert_start_in(convert_start_in), .din_in(din_in),
    .dout_out(dout_out), .dout_oe_out(dout_oe_out),
    .sample_connect_out(sample_connect_out), .converting_out(converting_out),
    .power_down_out(power_down_out), .cs_mode_out(cs_mode_out),
    .busy_ind_out(busy_ind_out)
);

// File: testbench/adc_host_model.sv
// host side model: serial clock in frames and sampling of the data pin
`timescale 1ns/1ps

module adc_host_model (
    // serial clock driven by the host
    output logic sclk_out,
    // data pin as seen at the device
    input wire logic dout_in,
    input wire logic dout_oe_in
);
    logic last_r;

    // clock stands low between frames
    initial begin
        sclk_out = 1'b0;
        last_r = 1'b0;
    end

    // n bits at 125 ns, each sampled just before its falling edge; the bench
    // starts a frame after the longest conversion, except where it means not to
    task automatic frame(input int n, output logic [31:0] q);
        logic lvl;
        q = 32'h0;
        for (int i = 0; i < n; i++) begin
            #62.5 sclk_out = 1'b1;
            #62.5;
            // released pin: the simulator would settle a float arbitrarily, so invert
            lvl = dout_oe_in ? dout_in : ~last_r;
            last_r = lvl;
            q = {q[30:0], lvl};
            sclk_out = 1'b0;
        end
    endtask
endmodule

// File: testbench/tb.sv
// self-checking bench for the converter sequencing and readout block
`timescale 1ns/1ps

module tb;
    typedef struct packed {
        logic strap;
        logic sel_din;
        logic busy;
        logic [17:0] pos;
        logic [17:0] neg;
    } row_t;

    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic cs = 1'b0;
    logic din = 1'b1;
    logic [17:0] pos = 18'h00000;
    logic [17:0] neg = 18'h00000;
    logic sclk, dout, oe, sc, conv, pd, csm, busy;
    logic [31:0] q;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    row_t rows [6];

    adc_conv_ctrl dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk),
        .convert_start_in(cs), .din_in(din),
        .analog_pos_input_in(pos), .analog_neg_input_in(neg),
        .dout_out(dout), .dout_oe_out(oe), .sample_connect_out(sc),
        .converting_out(conv), .power_down_out(pd), .cs_mode_out(csm),
        .busy_ind_out(busy)
    );

    adc_host_model host (.sclk_out(sclk), .dout_in(dout), .dout_oe_in(oe));

    always #12.5 clk_in = ~clk_in;

    // hang guard, well above the eleven hundred or so cycles the sequence needs
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // inputs always change the same small delay after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask

    // saturating signed difference, the code the readout should carry
    function automatic logic [17:0] diff(input logic [17:0] p, input logic [17:0] n);
        int d;
        d = int'(p) - int'(n);
        if (d > 131071) d = 131071;
        if (d < -131072) d = -131072;
        return d[17:0];
    endfunction

    task automatic check_rst();
        check({26'h0, oe, sc, conv, pd, csm, busy}, 32'h16);
    endtask

    // one conversion and readout in the option the row names
    task automatic run_row(input row_t r);
        int n;
        logic [31:0] e;
        cs = 1'b0;
        din = r.strap;
        pos = r.pos;
        neg = r.neg;
        tick(4);
        cs = 1'b1;
        // busy options lower the select before the shortest conversion can end
        tick(r.busy ? 5 : 40);
        if (r.sel_din) din = 1'b0;
        else cs = 1'b0;
        if (r.busy) tick(35);
        if (!r.strap) din = 1'b1;
        tick(4);
        n = r.busy ? 19 : 18;
        e = {14'h0, diff(r.pos, r.neg)};
        if (!r.strap) begin
            n = n + 6;
            e = {e[25:0], 6'h3F};
        end
        check(csm, r.strap);
        check(busy, r.busy);
        check({pd, sc}, 2'h3);
        host.frame(n, q);
        check(q, e);
        tick(6);
        check(oe, !r.strap);
        // let an edge pass before the next row drives din again
        if (r.sel_din) begin
            din = 1'b1;
            tick(1);
        end
    endtask

    initial begin
        // strap, select on din, busy bit, positive, negative: all six options
        rows = '{
            '{1'b1, 1'b0, 1'b0, 18'h3FFFF, 18'h00000},
            '{1'b1, 1'b0, 1'b1, 18'h00000, 18'h3FFFF},
            '{1'b1, 1'b1, 1'b0, 18'h00005, 18'h00009},
            '{1'b1, 1'b1, 1'b1, 18'h12345, 18'h02345},
            '{1'b0, 1'b0, 1'b0, 18'h00100, 18'h00100},
            '{1'b0, 1'b0, 1'b1, 18'h0AAAA, 18'h15555}
        };
        tick(2);
        check_rst();
        sys_rst_in = 1'b0;
        tick(3);
        foreach (rows[i]) run_row(rows[i]);
        // serial clock during a conversion, then select raised in mid-frame
        cs = 1'b0;
        din = 1'b1;
        pos = 18'h1C0F0;
        neg = 18'h00010;
        tick(4);
        cs = 1'b1;
        tick(4);
        host.frame(4, q);
        check(oe, 1'b0);
        tick(40);
        din = 1'b0;
        tick(4);
        host.frame(5, q);
        check(q, {14'h0, diff(pos, neg)} >> 13);
        din = 1'b1;
        tick(6);
        check(oe, 1'b0);
        // reset in the middle of a conversion
        cs = 1'b0;
        tick(2);
        cs = 1'b1;
        tick(10);
        sys_rst_in = 1'b1;
        cs = 1'b0;
        tick(2);
        check_rst();
        sys_rst_in = 1'b0;
        tick(4);
        check_rst();
        test_done();
    end
endmodule
